// ==== logic/cfo_core.sv ====
// core slice: mask handling, flags, low power, break and opcode subset
`default_nettype none
// Functional notes
// - mask set blocks maskable requests
// - push registers, set mask, then fetch vector
// - index high byte never stacked on entry
// - highest priority pending request serviced first
// - return pulls registers including old mask
// - reset sets mask; clear, wait and stop ops clear it
// - negative flag copies result bit 7
// - zero flag set on zero result
// - carry from add bit 7, shifts
// - wait clears mask, halts, exits
// - stop clears mask, halts, exits on external
// - stop exit waits for oscillator delay
// - break loads swi, vector normal or monitor
// - break after current instruction completes
// - return ends break once request gone
// - add with carry, eight modes; slice decodes immediate and stack offset only
// - add without carry, same layout
// - signed immediate add to stack/index
// - and clears overflow, keeps half/carry
// - shift left: bit7 to carry
// - shift right: keeps bit7, bit0 carry
// - carry clear branch: pc+2+offset
module cfo_core
	import cfo_pkg::*;
#(
	parameter int NIRQ = 4,
	parameter int STAB_CYCLES = OSC_STAB_CYC
) (
	input  wire logic            core_clk,
	input  wire logic            rst_n,
	input  wire logic            clkEn,
	input  wire logic [7:0]      memRdata,
	input  wire logic [NIRQ-1:0] irqReq,
	input  wire logic [NIRQ-1:0] irqExternal,
	input  wire logic            breakReq,
	input  wire logic            monitorMode,
	output logic      [15:0]     memAddr,
	output logic      [7:0]      memWdata,
	output logic                 memWe,
	output logic      [7:0]      ccr,
	output logic      [7:0]      accum,
	output logic      [15:0]     indexReg,
	output logic      [15:0]     stackPtr,
	output logic                 inWait,
	output logic                 inStop,
	output logic                 inBreak
);
	typedef enum logic [3:0] {
		ST_VEC_HI  = 4'b0000,
		ST_VEC_LO  = 4'b0001,
		ST_FETCH   = 4'b0010,
		ST_DECODE  = 4'b0011,
		ST_PAGE2   = 4'b0100,
		ST_OPER    = 4'b0101,
		ST_EXEC    = 4'b0110,
		ST_PUSH    = 4'b0111,
		ST_PULL    = 4'b1000,
		ST_SLEEP   = 4'b1001,
		ST_STAB    = 4'b1010,
		ST_SPREAD  = 4'b1011
	} cfo_state_e;

	cfo_state_e state_reg;
	logic [15:0] pc_reg, addr_reg, vecAddr_reg;
	logic [7:0]  op_reg, opnd_reg, ccr_reg, a_reg, x_reg, h_reg;
	logic [15:0] sp_reg;
	logic [2:0]  step_reg;
	logic        page2_reg, stop_reg, wait_reg, brk_reg, we_reg;
	logic [7:0]  wd_reg;
	logic        stabStart_reg;
	logic        stabBusy;
	logic [7:0]  aluRes, aluCc;
	logic [2:0]  aluOp;
	logic [NIRQ-1:0] irqSel;
	logic        irqAny, irqWake;
	logic [15:0] sext;

	cfo_alu u_alu (
		.op    (aluOp),
		.a     (op_reg == OP_ASL_X || op_reg == OP_ASR_X ? x_reg : a_reg),
		.b     (opnd_reg),
		.ccIn  (ccr_reg),
		.res   (aluRes),
		.ccOut (aluCc)
	);

	cfo_stab_timer #(.CYCLES(STAB_CYCLES)) u_stab (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.start    (stabStart_reg),
		.busy     (stabBusy)
	);

	// lowest index wins: fixed priority pick
	always_comb begin
		irqSel = '0;
		for (int i = NIRQ-1; i >= 0; i--) begin
			if (irqReq[i]) irqSel = NIRQ'(1) << i;
		end
	end
	assign irqAny = |irqReq && !ccr_reg[CC_I];
	assign irqWake = stop_reg ? |(irqReq & irqExternal) : |irqReq;
	assign sext = {{8{opnd_reg[7]}}, opnd_reg};

	// alu selection from the full opcode
	always_comb begin
		unique case (op_reg)
			OP_ADC_IMM, OP_ADC_SP1: aluOp = 3'(CFO_ALU_ADC);
			OP_AND_IMM, OP_AND_SP1: aluOp = 3'(CFO_ALU_AND);
			OP_ASL_A, OP_ASL_X:     aluOp = 3'(CFO_ALU_ASL);
			OP_ASR_A, OP_ASR_X:     aluOp = 3'(CFO_ALU_ASR);
			default:                aluOp = 3'(CFO_ALU_ADD);
		endcase
	end

	// main sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= ST_VEC_HI;
			pc_reg <= 16'h0000;
			addr_reg <= VEC_RESET;
			vecAddr_reg <= VEC_RESET;
			op_reg <= 8'h00;
			opnd_reg <= 8'h00;
			ccr_reg <= CCR_RESET;
			a_reg <= 8'h00;
			x_reg <= 8'h00;
			h_reg <= 8'h00;
			sp_reg <= SP_RESET;
			step_reg <= 3'd0;
			page2_reg <= 1'b0;
			stop_reg <= 1'b0;
			wait_reg <= 1'b0;
			brk_reg <= 1'b0;
			we_reg <= 1'b0;
			wd_reg <= 8'h00;
			stabStart_reg <= 1'b0;
		end else if (clkEn) begin
			we_reg <= 1'b0;
			stabStart_reg <= 1'b0;
			unique case (state_reg)
				ST_VEC_HI: begin
					pc_reg[15:8] <= memRdata;
					addr_reg <= vecAddr_reg + 16'h0001;
					state_reg <= ST_VEC_LO;
				end
				ST_VEC_LO: begin
					pc_reg[7:0] <= memRdata;
					addr_reg <= {pc_reg[15:8], memRdata};
					state_reg <= ST_FETCH;
				end
				ST_FETCH: begin
					// break or interrupt at instruction boundary
					if (breakReq && !brk_reg) begin
						op_reg <= OP_SWI;
						brk_reg <= 1'b1;
						vecAddr_reg <= monitorMode ? VEC_BRK_MON : VEC_SWI;
						step_reg <= 3'd0;
						state_reg <= ST_PUSH;
					end else if (irqAny) begin
						vecAddr_reg <= VEC_IRQ_BASE
							- {11'h000, 5'(irqIdx(irqSel)) << 1};
						step_reg <= 3'd0;
						state_reg <= ST_PUSH;
					end else begin
						op_reg <= memRdata;
						page2_reg <= 1'b0;
						pc_reg <= pc_reg + 16'h0001;
						addr_reg <= pc_reg + 16'h0001;
						state_reg <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					if (op_reg == OP_PREFIX) begin
						op_reg <= memRdata;
						page2_reg <= 1'b1;
						pc_reg <= pc_reg + 16'h0001;
						addr_reg <= pc_reg + 16'h0001;
						state_reg <= ST_PAGE2;
					end else begin
						unique case (op_reg)
							OP_CLI: begin
								ccr_reg[CC_I] <= 1'b0;
								state_reg <= ST_FETCH;
							end
							OP_WAIT, OP_STOP: begin
								ccr_reg[CC_I] <= 1'b0;
								wait_reg <= (op_reg == OP_WAIT);
								stop_reg <= (op_reg == OP_STOP);
								state_reg <= ST_SLEEP;
							end
							OP_ASL_A, OP_ASR_A: begin
								a_reg <= aluRes;
								ccr_reg <= aluCc;
								state_reg <= ST_FETCH;
							end
							OP_ASL_X, OP_ASR_X: begin
								x_reg <= aluRes;
								ccr_reg <= aluCc;
								state_reg <= ST_FETCH;
							end
							OP_RTI: begin
								addr_reg <= sp_reg + 16'h0001;
								sp_reg <= sp_reg + 16'h0001;
								step_reg <= 3'd0;
								state_reg <= ST_PULL;
							end
							OP_PUSH_INDEX_HIGH_OP: begin
								memWdata_set(h_reg);
								state_reg <= ST_FETCH;
							end
							OP_SWI: begin
								vecAddr_reg <= VEC_SWI;
								step_reg <= 3'd0;
								state_reg <= ST_PUSH;
							end
							default: begin
								opnd_reg <= memRdata;
								pc_reg <= pc_reg + 16'h0001;
								addr_reg <= pc_reg + 16'h0001;
								state_reg <= ST_OPER;
							end
						endcase
					end
				end
				ST_PAGE2: begin
					// stack relative 8-bit offset forms
					opnd_reg <= memRdata;
					pc_reg <= pc_reg + 16'h0001;
					addr_reg <= sp_reg + {8'h00, memRdata};
					state_reg <= ST_SPREAD;
				end
				ST_SPREAD: begin
					opnd_reg <= memRdata;
					state_reg <= ST_EXEC;
				end
				ST_OPER: begin
					state_reg <= ST_EXEC;
				end
				ST_EXEC: begin
					addr_reg <= pc_reg;
					state_reg <= ST_FETCH;
					unique case (op_reg)
						OP_AIS: sp_reg <= sp_reg + sext;
						OP_AIX: {h_reg, x_reg} <= {h_reg, x_reg} + sext;
						OP_BCC: begin
							if (!ccr_reg[CC_C]) begin
								pc_reg <= pc_reg + sext;
								addr_reg <= pc_reg + sext;
							end
						end
						OP_PULL_INDEX_HIGH_OP: h_reg <= opnd_reg;
						default: begin
							a_reg <= aluRes;
							ccr_reg <= aluCc;
						end
					endcase
				end
				ST_PUSH: begin
					// push pc lo, pc hi, x, a, ccr; h is left alone
					we_reg <= 1'b1;
					addr_reg <= sp_reg;
					sp_reg <= sp_reg - 16'h0001;
					step_reg <= step_reg + 3'd1;
					unique case (step_reg)
						3'd0: wd_reg <= pc_reg[7:0];
						3'd1: wd_reg <= pc_reg[15:8];
						3'd2: wd_reg <= x_reg;
						3'd3: wd_reg <= a_reg;
						3'd4: wd_reg <= ccr_reg;
						default: begin
							// ccr written last cycle; mask now, then vector
							we_reg <= 1'b0;
							sp_reg <= sp_reg;
							ccr_reg[CC_I] <= 1'b1;
							addr_reg <= vecAddr_reg;
							state_reg <= ST_VEC_HI;
						end
					endcase
				end
				ST_PULL: begin
					addr_reg <= sp_reg + 16'h0001;
					sp_reg <= sp_reg + 16'h0001;
					step_reg <= step_reg + 3'd1;
					unique case (step_reg)
						3'd0: ccr_reg <= memRdata | 8'h60;
						3'd1: a_reg <= memRdata;
						3'd2: x_reg <= memRdata;
						3'd3: pc_reg[15:8] <= memRdata;
						default: begin
							sp_reg <= sp_reg;
							pc_reg[7:0] <= memRdata;
							addr_reg <= {pc_reg[15:8], memRdata};
							if (!breakReq) brk_reg <= 1'b0;
							state_reg <= ST_FETCH;
						end
					endcase
				end
				ST_SLEEP: begin
					if (irqWake) begin
						wait_reg <= 1'b0;
						stop_reg <= 1'b0;
						stabStart_reg <= stop_reg;
						state_reg <= stop_reg ? ST_STAB : ST_FETCH;
					end
				end
				ST_STAB: begin
					if (!stabBusy && !stabStart_reg) begin
						state_reg <= ST_FETCH;
					end
				end
				default: state_reg <= ST_FETCH;
			endcase
		end
	end

	// push of the index high byte writes one byte
	task automatic memWdata_set(input logic [7:0] d);
		we_reg <= 1'b1;
		wd_reg <= d;
		addr_reg <= sp_reg;
		sp_reg <= sp_reg - 16'h0001;
	endtask

	function automatic logic [4:0] irqIdx(input logic [NIRQ-1:0] s);
		irqIdx = 5'd0;
		for (int i = 0; i < NIRQ; i++) begin
			if (s[i]) irqIdx = 5'(i);
		end
	endfunction

	// outputs straight from registers
	assign memAddr = addr_reg;
	assign memWdata = wd_reg;
	assign memWe = we_reg;
	assign ccr = ccr_reg;
	assign accum = a_reg;
	assign indexReg = {h_reg, x_reg};
	assign stackPtr = sp_reg;
	assign inWait = wait_reg;
	assign inStop = stop_reg;
	assign inBreak = brk_reg;
endmodule
`default_nettype wire

// ==== logic/cfo_pkg.sv ====
// package: opcodes, flag positions, vectors and timing for the core slice
`default_nettype none
package cfo_pkg;
	// condition code bit positions
	localparam int CC_C = 0;
	localparam int CC_Z = 1;
	localparam int CC_N = 2;
	localparam int CC_I = 3;
	localparam int CC_H = 4;
	localparam int CC_V = 7;
	localparam logic [7:0] CCR_RESET = 8'h68; // bits 6,5 fixed, mask set
	localparam logic [15:0] SP_RESET = 16'h00FF;
	// vectors
	localparam logic [15:0] VEC_RESET     = 16'hFFFE;
	localparam logic [15:0] VEC_SWI       = 16'hFFFC;
	localparam logic [15:0] VEC_BRK_MON   = 16'hFEFC;
	localparam logic [15:0] VEC_IRQ_BASE  = 16'hFFFA;
	// opcodes
	localparam logic [7:0] OP_PREFIX   = 8'h9E;
	localparam logic [7:0] OP_ADC_IMM  = 8'hA9;
	localparam logic [7:0] OP_ADD_IMM  = 8'hAB;
	localparam logic [7:0] OP_AND_IMM  = 8'hA4;
	localparam logic [7:0] OP_ADC_SP1  = 8'hE9;
	localparam logic [7:0] OP_ADD_SP1  = 8'hEB;
	localparam logic [7:0] OP_AND_SP1  = 8'hE4;
	localparam logic [7:0] OP_AIS      = 8'hA7;
	localparam logic [7:0] OP_AIX      = 8'hAF;
	localparam logic [7:0] OP_ASL_A    = 8'h48;
	localparam logic [7:0] OP_ASL_X    = 8'h58;
	localparam logic [7:0] OP_ASR_A    = 8'h47;
	localparam logic [7:0] OP_ASR_X    = 8'h57;
	localparam logic [7:0] OP_BCC      = 8'h24;
	localparam logic [7:0] OP_RTI      = 8'h80;
	localparam logic [7:0] OP_CLI      = 8'h9A;
	localparam logic [7:0] OP_SWI      = 8'h83;
	localparam logic [7:0] OP_WAIT     = 8'h8F;
	localparam logic [7:0] OP_STOP     = 8'h8E;
	localparam logic [7:0] OP_PUSH_INDEX_HIGH_OP     = 8'h8B;
	localparam logic [7:0] OP_PULL_INDEX_HIGH_OP     = 8'h8A;
	// alu operation select
	typedef enum logic [2:0] {
		CFO_ALU_ADD = 3'b000,
		CFO_ALU_ADC = 3'b001,
		CFO_ALU_AND = 3'b010,
		CFO_ALU_ASL = 3'b011,
		CFO_ALU_ASR = 3'b100
	} cfo_alu_e;
	// oscillator stabilization delay after stop
	localparam int OSC_STAB_NS = 81920;
	localparam int CLK_PERIOD_NS = 20;
	localparam int OSC_STAB_CYC = OSC_STAB_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== logic/cfo_alu.sv ====
// alu: add, add with carry, and, shifts with condition code results
`default_nettype none
module cfo_alu
	import cfo_pkg::*;
(
	input  wire logic [2:0] op,
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic [7:0] ccIn,
	output logic      [7:0] res,
	output logic      [7:0] ccOut
);
	logic [8:0] sum;
	logic [4:0] half;
	logic       cin;
	// result and flags per operation
	always_comb begin
		cin = (op == 3'(CFO_ALU_ADC)) ? ccIn[CC_C] : 1'b0;
		sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		ccOut = ccIn;
		res = sum[7:0];
		unique case (op)
			3'(CFO_ALU_ADD), 3'(CFO_ALU_ADC): begin
				res = sum[7:0];
				ccOut[CC_C] = sum[8];
				ccOut[CC_H] = half[4];
				ccOut[CC_V] = (a[7] == b[7]) && (sum[7] != a[7]);
			end
			3'(CFO_ALU_AND): begin
				res = a & b;
				ccOut[CC_V] = 1'b0;
			end
			3'(CFO_ALU_ASL): begin
				res = {a[6:0], 1'b0};
				ccOut[CC_C] = a[7];
				ccOut[CC_V] = a[7] ^ a[6];
			end
			3'(CFO_ALU_ASR): begin
				res = {a[7], a[7:1]};
				ccOut[CC_C] = a[0];
				ccOut[CC_V] = a[7] ^ a[0];
			end
			default: begin
				res = 8'h00;
			end
		endcase
		ccOut[CC_N] = res[7];
		ccOut[CC_Z] = (res == 8'h00);
	end
endmodule
`default_nettype wire

// ==== logic/cfo_stab_timer.sv ====
// countdown for the oscillator stabilization delay after stop
`default_nettype none
module cfo_stab_timer #(
	parameter int CYCLES = 4096
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	input  wire logic start,
	output logic      busy
);
	logic [$clog2(CYCLES+1)-1:0] cnt_reg;
	// load on start, count down to zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (clkEn) begin
			if (start) begin
				cnt_reg <= ($clog2(CYCLES+1))'(CYCLES);
			end else if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
	assign busy = (cnt_reg != '0);
endmodule
`default_nettype wire

// ==== verif/cfo_mem_model.sv ====
// zero-wait memory model on the far side of the core bus
`default_nettype none
module cfo_mem_model (
	input  wire logic        core_clk,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	input  wire logic        memWe,
	output logic      [7:0]  memRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	// read follows the held address in the same cycle
	assign memRdata = mem[memAddr];
	// one byte stored per write pulse
	always @(posedge core_clk) begin
		if (memWe === 1'b1) begin
			mem[memAddr] <= memWdata;
		end
	end
endmodule
`default_nettype wire

// ==== verif/cfo_core_sva.sv ====
// concurrent checks on the core slice ports
`default_nettype none
module cfo_core_sva
	import cfo_pkg::*;
#(
	parameter int NIRQ        = 4,
	parameter int STAB_CYCLES = 8
) (
	input wire logic            core_clk,
	input wire logic            rst_n,
	input wire logic            clkEn,
	input wire logic [NIRQ-1:0] irqReq,
	input wire logic [NIRQ-1:0] irqExternal,
	input wire logic            breakReq,
	input wire logic            monitorMode,
	input wire logic [15:0]     memAddr,
	input wire logic            memWe,
	input wire logic [7:0]      ccr,
	input wire logic [15:0]     stackPtr,
	input wire logic            inWait,
	input wire logic            inStop,
	input wire logic            inBreak
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// reset values, checked one cycle after reset is sampled low
	property p_rst;
		disable iff (1'b0)
		!rst_n |=> ccr == CCR_RESET && stackPtr == SP_RESET;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset value wrong");
	// mask only rises on the cycle after a stack push
	property p_push_mask;
		$rose(ccr[CC_I]) && $past(rst_n) |-> $past(memWe);
	endproperty
	a_push_mask: assert property (p_push_mask)
		else $error("mask set without push");
	property p_wait_mask;
		$rose(inWait) |-> ##[0:2] !ccr[CC_I];
	endproperty
	a_wait_mask: assert property (p_wait_mask)
		else $error("wait kept mask");
	property p_stop_mask;
		$rose(inStop) |-> ##[0:2] !ccr[CC_I];
	endproperty
	a_stop_mask: assert property (p_stop_mask)
		else $error("stop kept mask");
	// stopped core neither moves the bus nor writes
	property p_stop_quiet;
		inStop && $past(inStop) |-> $stable(memAddr) && !memWe;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("bus active in stop");
	property p_stop_refuse;
		inStop && !(|(irqReq & irqExternal)) && !breakReq |=> inStop;
	endproperty
	a_stop_refuse: assert property (p_stop_refuse)
		else $error("stop left without wake");
	property p_wait_hold;
		inWait && !(|irqReq) && !breakReq |=> inWait;
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("wait left without request");
	// bench runs with eight stabilization cycles
	property p_stab;
		inStop && $rose(|(irqReq & irqExternal)) |=> $stable(memAddr) [*7];
	endproperty
	a_stab: assert property (p_stab)
		else $error("ran before stabilization");
	property p_mon_vec;
		memAddr == VEC_BRK_MON |-> monitorMode;
	endproperty
	a_mon_vec: assert property (p_mon_vec)
		else $error("monitor vector outside monitor mode");
	property p_prio;
		memAddr == VEC_IRQ_BASE - 16'h0002 |-> !irqReq[0];
	endproperty
	a_prio: assert property (p_prio)
		else $error("lower request served first");
	property p_freeze;
		!clkEn |=> $stable(memAddr) && $stable(ccr);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while frozen");
	c_wait: cover property ($rose(inWait));
	c_stop: cover property ($rose(inStop));
	c_brk: cover property ($rose(inBreak));
endmodule
bind cfo_core cfo_core_sva #(
	.NIRQ        (NIRQ),
	.STAB_CYCLES (STAB_CYCLES)
) i_sva (
	.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
	.irqReq(irqReq), .irqExternal(irqExternal), .breakReq(breakReq),
	.monitorMode(monitorMode), .memAddr(memAddr), .memWe(memWe),
	.ccr(ccr), .stackPtr(stackPtr), .inWait(inWait),
	.inStop(inStop), .inBreak(inBreak)
);
`default_nettype wire

// ==== verif/cpu_flags_and_opcode_subset_test.sv ====
// self-checking bench running a small program on the core slice
`default_nettype none
module cpu_flags_and_opcode_subset_test
	import cfo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STAB = 8;
	localparam logic [7:0] PROG [0:44] = '{
		8'hAB, 8'h80, 8'hA7, 8'h00, 8'hAB, 8'h80, 8'hA7, 8'h00,
		8'hA4, 8'h00, 8'hA7, 8'h00, 8'hA9, 8'h05, 8'hA7, 8'h00,
		8'hAB, 8'hFA, 8'hA7, 8'h00, 8'hAB, 8'hC1, 8'hA7, 8'h00,
		8'h48, 8'hA7, 8'h00, 8'h47, 8'hA7, 8'h00, 8'hAF, 8'h7F,
		8'hA7, 8'hFE, 8'h24, 8'h02, 8'hAB, 8'h01, 8'hA7, 8'h00,
		8'h9A, 8'h8F, 8'h8E, 8'h24, 8'hFE};
	// check point, accumulator, flags, flag mask
	localparam logic [39:0] STEPS [0:8] = '{
		40'h8002_80_6C_FF,
		40'h8006_00_EB_FF,
		40'h800A_00_6B_FF,
		40'h800E_06_68_FF,
		40'h8012_00_7B_FF,
		40'h8016_C1_6C_FF,
		40'h8019_82_6D_7F,
		40'h801C_C1_6C_7F,
		40'h8026_C1_6C_7F};
	localparam logic [15:0] VECS [0:5] = '{16'hFFFA, 16'hFFF8, 16'hFFF6,
		VEC_SWI, VEC_BRK_MON, 16'h9000};
	logic        core_clk;
	logic        rst_n;
	logic        clkEn;
	logic [3:0]  irqReq;
	logic [3:0]  irqExternal;
	logic        breakReq;
	logic        monitorMode;
	logic [7:0]  memRdata;
	logic [15:0] memAddr;
	logic [7:0]  memWdata;
	logic        memWe;
	logic [7:0]  ccr;
	logic [7:0]  accum;
	logic [15:0] indexReg;
	logic [15:0] stackPtr;
	logic        inWait;
	logic        inStop;
	logic        inBreak;
	logic [15:0] a0;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	int          nWr = 0;
	int          cnt;
	cfo_core #(
		.NIRQ        (4),
		.STAB_CYCLES (STAB)
	) i_dut (
		.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
		.memRdata(memRdata), .irqReq(irqReq), .irqExternal(irqExternal),
		.breakReq(breakReq), .monitorMode(monitorMode),
		.memAddr(memAddr), .memWdata(memWdata), .memWe(memWe),
		.ccr(ccr), .accum(accum), .indexReg(indexReg),
		.stackPtr(stackPtr), .inWait(inWait), .inStop(inStop),
		.inBreak(inBreak)
	);
	cfo_mem_model i_mem (
		.core_clk(core_clk), .memAddr(memAddr), .memWdata(memWdata),
		.memWe(memWe), .memRdata(memRdata)
	);
	// clock
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;
	// cycle ceiling and write counter
	always @(posedge core_clk) begin
		cyc++;
		if (memWe === 1'b1) nWr++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out;
		end
	end
	task automatic close_out;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input logic [15:0] m);
		checked++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask
	// wait for the core to present an address
	task automatic go(input logic [15:0] a);
		do tick; while (memAddr !== a);
	endtask
	task automatic bit1(input logic b, input logic e);
		chk({15'h0000, b}, {15'h0000, e}, 16'h0001);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		irqReq = 4'h0;
		irqExternal = 4'h0;
		breakReq = 1'b0;
		monitorMode = 1'b0;
		foreach (PROG[i]) i_mem.mem[16'h8000 + i] = PROG[i];
		foreach (VECS[i]) i_mem.mem[VECS[i]] = 8'h90;
		foreach (VECS[i]) i_mem.mem[VECS[i] + 16'h0001] = 8'h00;
		i_mem.mem[16'hFFFE] = 8'h80;
		i_mem.mem[16'hFFFF] = 8'h00;
		i_mem.mem[16'h9000] = 8'h80;
		i_mem.mem[16'h00F8] = 8'hAA;
		repeat (4) tick;
		rst_n = 1'b1;
		foreach (STEPS[i]) begin
			irqReq = (i >= 5 && i < 8) ? 4'h1 : 4'h0;
			go(STEPS[i][39:24]);
			repeat (2) tick;
			chk({8'h00, accum}, {8'h00, STEPS[i][23:16]}, 16'h00FF);
			chk({8'h00, ccr}, {8'h00, STEPS[i][15:8]},
				{8'h00, STEPS[i][7:0]});
		end
		chk(stackPtr, 16'h00FD, 16'hFFFF);
		chk(indexReg, 16'h007F, 16'hFFFF);
		while (inWait !== 1'b1) tick;
		bit1(ccr[CC_I], 1'b0);
		chk(nWr[15:0], 16'h0000, 16'hFFFF);
		irqReq = 4'h3;
		go(16'hFFFA);
		irqReq = 4'h2;
		go(16'h9000);
		bit1(ccr[CC_I], 1'b1);
		chk(nWr[15:0], 16'h0005, 16'hFFFF);
		chk({i_mem.mem[16'h00FC], i_mem.mem[16'h00FD]}, 16'h802A, 16'hFFFF);
		chk({i_mem.mem[16'h00FB], i_mem.mem[16'h00FA]}, 16'h7FC1, 16'hFFFF);
		chk({i_mem.mem[16'h00F9], i_mem.mem[16'h00F8]}, 16'h00AA, 16'h08FF);
		go(16'hFFF8);
		irqReq = 4'h0;
		go(16'h802A);
		bit1(ccr[CC_I], 1'b0);
		while (inStop !== 1'b1) tick;
		bit1(ccr[CC_I], 1'b0);
		irqReq = 4'h4;
		repeat (10) tick;
		bit1(inStop, 1'b1);
		a0 = memAddr;
		irqExternal = 4'h4;
		cnt = 0;
		while (memAddr === a0) begin
			tick;
			cnt++;
		end
		bit1(cnt >= STAB, 1'b1);
		go(16'hFFF6);
		irqReq = 4'h0;
		go(16'h802B);
		bit1(ccr[CC_I], 1'b0);
		clkEn = 1'b0;
		repeat (4) tick;
		clkEn = 1'b1;
		for (int m = 0; m < 2; m++) begin
			monitorMode = m[0];
			breakReq = 1'b1;
			go(m[0] ? VEC_BRK_MON : VEC_SWI);
			go(16'h9000);
			bit1(inBreak, 1'b1);
			breakReq = 1'b0;
			go(16'h802B);
			tick;
			bit1(inBreak, 1'b0);
		end
		rst_n = 1'b0;
		repeat (2) tick;
		chk({8'h00, ccr}, {8'h00, CCR_RESET}, 16'hFFFF);
		rst_n = 1'b1;
		close_out;
	end
endmodule
`default_nettype wire
